//--- rtl/sdp_pkg.sv
// Behaviour
// - 96 two-way lines as twelve 8-bit ports, bit 7 most significant.
// - each line is a software-read input or a software-driven output.
// - port build: direction set per whole port, eight lines together.
// - line build: direction set independently for every single line.
// - inputs sampled and outputs updated only by a software access.
// - line build: per-line pull, down engages weak, up engages strong.
// - pull applies in any direction, outputs still show their driven value.
package sdp_pkg;
  localparam int unsigned SDP_NPORT = 12;
  localparam int unsigned SDP_PW = 8;
  localparam int unsigned SDP_NLINE = 96;
  localparam int unsigned SDP_NWORD = 3;
  // register byte offsets, each group holds three words
  localparam logic [31:0] SDP_OUT_BASE = 32'h0000_0000;
  localparam logic [31:0] SDP_DIR_BASE = 32'h0000_0010;
  localparam logic [31:0] SDP_PULL_BASE = 32'h0000_0020;
  localparam logic [31:0] SDP_IN_BASE = 32'h0000_0030;
  localparam logic [31:0] SDP_PDIR_OFS = 32'h0000_0040;
  // values after reset: lines are inputs, outputs low, pull-down chosen in the line build
  localparam logic [31:0] SDP_OUT_RST = 32'h0000_0000;
  localparam logic [31:0] SDP_DIR_RST = 32'h0000_0000;
  localparam logic [31:0] SDP_PULL_RST = 32'h0000_0000;
  localparam logic [31:0] SDP_PDN_RST = 32'hFFFF_FFFF;
  localparam logic [2:0] SDP_HSIZE_WORD = 3'h2;
  localparam logic [1:0] SDP_HRESP_OKAY = 2'h0;

  // true when addr is word w of the group starting at base
  function automatic logic sdp_hit(input logic [31:0] a,
                                   input logic [31:0] base,
                                   input logic [1:0] w);
    return a == (base + {28'h000_0000, w, 2'h0});
  endfunction
endpackage

//--- rtl/sdp_sync.sv
`timescale 1ns/1ns
module sdp_sync #(
  parameter int unsigned WIDTH = 96
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous pins and their settled view
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] level_q;

  // a bit only moves once the second and third stages agree on it
  assign agree = ~(s2_q ^ s3_q);
  assign level = level_q;

  // s1 feeds s2 alone, so metastability never reaches the compare
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (agree & s3_q) | (~agree & level_q);
    end
  end
endmodule // sdp_sync

//--- rtl/sdp_top.sv
`timescale 1ns/1ns
module sdp_top #(
  // 1: direction and pull per line, 0: direction per port, no pull
  parameter bit LINE_GRAN = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // bidirectional_io_line pins
  input wire logic [sdp_pkg::SDP_NLINE-1:0] io_in,
  output logic [sdp_pkg::SDP_NLINE-1:0] io_out,
  output logic [sdp_pkg::SDP_NLINE-1:0] io_oe,
  // pull resistor enables
  output logic [sdp_pkg::SDP_NLINE-1:0] pull_up_en,
  output logic [sdp_pkg::SDP_NLINE-1:0] pull_dn_en
);
  import sdp_pkg::*;

  localparam int unsigned NL = SDP_NLINE;
  logic [NL-1:0] out_q;
  logic [NL-1:0] dir_q;
  logic [NL-1:0] pup_q;
  logic [NL-1:0] pdn_q;
  logic [NL-1:0] in_sync;
  logic [NL-1:0] in_view;
  logic [NL-1:0] pdir_exp;
  logic [SDP_NPORT-1:0] pdir_view;
  logic [SDP_NWORD-1:0] wr_out;
  logic [SDP_NWORD-1:0] wr_dir;
  logic [SDP_NWORD-1:0] wr_pull;
  logic [SDP_NWORD-1:0] dir_we;
  logic [SDP_NWORD-1:0] hit_out;
  logic [SDP_NWORD-1:0] hit_dir;
  logic [SDP_NWORD-1:0] hit_pull;
  logic [SDP_NWORD-1:0] hit_in;
  logic [31:0] rd_part [SDP_NWORD];
  logic [31:0] rd_data;
  logic [31:0] rd_pdir;
  logic [31:0] dp_addr_q;
  logic dp_wr_q;
  logic hrdy_q;
  logic [31:0] hrdata_q;
  logic [1:0] hresp_q;
  logic ap_take;
  logic ap_rd;
  logic wr_pdir;

  // pins cross into the clock domain before any read can see them
  sdp_sync #(
    .WIDTH(NL)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin(io_in),
    .level(in_sync)
  );

  // address phase: only whole-word transfers are taken
  assign ap_take = hsel && hready && htrans[1] && (hsize == SDP_HSIZE_WORD);
  assign ap_rd = ap_take && !hwrite;
  // port direction word is live only in the port build
  assign wr_pdir = !LINE_GRAN && dp_wr_q && (dp_addr_q == SDP_PDIR_OFS);

  // zero wait states, so ready stays high and every answer is okay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 32'h0000_0000;
      hrdy_q <= 1'b0;
      hresp_q <= SDP_HRESP_OKAY;
    end else begin
      dp_wr_q <= ap_take && hwrite;
      dp_addr_q <= haddr;
      hrdy_q <= 1'b1;
      hresp_q <= SDP_HRESP_OKAY;
    end
  end

  // read data sampled at the address phase edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ap_rd) begin
      hrdata_q <= rd_data;
    end
  end

  assign hreadyout = hrdy_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign io_out = out_q;
  assign io_oe = dir_q;
  assign pull_up_en = pup_q;
  assign pull_dn_en = pdn_q;

  // output lines report their driven value, inputs the settled pin
  assign in_view = (dir_q & out_q) | (~dir_q & in_sync);

  // one port bit fans out to its eight lines
  genvar p;
  generate
    for (p = 0; p < SDP_NPORT; p++) begin : g_port
      assign pdir_exp[p*SDP_PW +: SDP_PW] = {SDP_PW{hwdata[p % 32]}};
      assign pdir_view[p] = LINE_GRAN ? 1'b0 : dir_q[p*SDP_PW];
    end
  endgenerate
  assign rd_pdir = {20'h0_0000, pdir_view};

  // per-word registers: output latch, direction and pull
  genvar w;
  generate
    for (w = 0; w < SDP_NWORD; w++) begin : g_word
      assign wr_out[w] = dp_wr_q && sdp_hit(dp_addr_q, SDP_OUT_BASE, 2'(w));
      assign wr_dir[w] = dp_wr_q && sdp_hit(dp_addr_q, SDP_DIR_BASE, 2'(w));
      assign wr_pull[w] = LINE_GRAN && dp_wr_q &&
                          sdp_hit(dp_addr_q, SDP_PULL_BASE, 2'(w));
      // line build takes the direction word, port build the port word
      assign dir_we[w] = LINE_GRAN ? wr_dir[w] : wr_pdir;
      // read decode looks at the live address phase
      assign hit_out[w] = sdp_hit(haddr, SDP_OUT_BASE, 2'(w));
      assign hit_dir[w] = sdp_hit(haddr, SDP_DIR_BASE, 2'(w));
      assign hit_pull[w] = sdp_hit(haddr, SDP_PULL_BASE, 2'(w));
      assign hit_in[w] = sdp_hit(haddr, SDP_IN_BASE, 2'(w));
      assign rd_part[w] =
        ({32{hit_out[w]}} & out_q[w*32 +: 32]) |
        ({32{hit_dir[w]}} & dir_q[w*32 +: 32]) |
        ({32{hit_pull[w]}} & pup_q[w*32 +: 32]) |
        ({32{hit_in[w]}} & in_view[w*32 +: 32]);

      // output value holds until the next write to its word
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          out_q[w*32 +: 32] <= SDP_OUT_RST;
        end else if (wr_out[w]) begin
          out_q[w*32 +: 32] <= hwdata;
        end
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          dir_q[w*32 +: 32] <= SDP_DIR_RST;
        end else if (dir_we[w]) begin
          dir_q[w*32 +: 32] <= LINE_GRAN ? hwdata : pdir_exp[w*32 +: 32];
        end
      end

      // pull ignores direction; the port build has no pull at all
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pup_q[w*32 +: 32] <= SDP_PULL_RST;
          pdn_q[w*32 +: 32] <= LINE_GRAN ? SDP_PDN_RST : SDP_PULL_RST;
        end else if (wr_pull[w]) begin
          pup_q[w*32 +: 32] <= hwdata;
          pdn_q[w*32 +: 32] <= ~hwdata;
        end
      end
    end
  endgenerate

  // unmapped offsets read as zero, writes to them are dropped
  assign rd_data = rd_part[0] | rd_part[1] | rd_part[2] |
                   ({32{haddr == SDP_PDIR_OFS}} & rd_pdir);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence out0_wr_s;
    ap_take && hwrite && (haddr == SDP_OUT_BASE) ##1 1'b1;
  endsequence

  sequence dir0_wr_s;
    ap_take && hwrite && (haddr == SDP_DIR_BASE) ##1 1'b1;
  endsequence

  sequence pull_wr_s;
    dp_wr_q && (dp_addr_q[31:4] == SDP_PULL_BASE[31:4]);
  endsequence

  sequence in0_rd_s;
    ap_rd && (haddr == SDP_IN_BASE);
  endsequence

  sequence dir0_rd_s;
    ap_rd && (haddr == SDP_DIR_BASE);
  endsequence

  sequence pdir_rd_s;
    ap_rd && (haddr == SDP_PDIR_OFS);
  endsequence

  sequence pdir_wr_s;
    dp_wr_q && (dp_addr_q == SDP_PDIR_OFS);
  endsequence

  sequence pull0_wr_s;
    ap_take && hwrite && (haddr == SDP_PULL_BASE) ##1 1'b1;
  endsequence

  sequence odd_size_s;
    hsel && hready && htrans[1] && (hsize != SDP_HSIZE_WORD);
  endsequence

  out_write_a: assert property (out0_wr_s |=>
    io_out[31:0] == $past(hwdata))
    else $error("output word 0 did not take written data");

  logic any_out_wr;
  assign any_out_wr = |wr_out;
  out_hold_a: assert property (!any_out_wr |=> $stable(io_out))
    else $error("output lines moved without a write");

  logic [SDP_NPORT-1:0] port_mixed;
  generate
    for (p = 0; p < SDP_NPORT; p++) begin : g_chk
      assign port_mixed[p] = !((&dir_q[p*SDP_PW +: SDP_PW]) ||
                               !(|dir_q[p*SDP_PW +: SDP_PW]));
    end
  endgenerate
  port_dir_a: assert property (!LINE_GRAN |-> port_mixed == '0)
    else $error("port build holds a port with mixed directions");

  line_dir_a: assert property (LINE_GRAN ##0 dir0_wr_s |=>
    io_oe[31:0] == $past(hwdata))
    else $error("line direction word 0 not applied");

  pull_excl_a: assert property (LINE_GRAN |->
    ((pull_up_en ^ pull_dn_en) == {NL{1'b1}}))
    else $error("pull-up and pull-down not exclusive");

  pull_none_a: assert property (!LINE_GRAN |->
    (pull_up_en == '0) && (pull_dn_en == '0))
    else $error("port build drives a pull enable");

  pull_dir_a: assert property (pull_wr_s |=>
    $stable(io_oe) && $stable(io_out))
    else $error("pull write disturbed direction or output");

  in_read_a: assert property (in0_rd_s ##0 $stable(io_oe) |=>
    ((hrdata ^ $past(in_sync[31:0])) & ~$past(io_oe[31:0])) == 32'h0000_0000)
    else $error("input read does not show synchronised pins");

  sync_lat_a: assert property (
    (io_in == $past(io_in))[*5] |-> in_sync == io_in)
    else $error("settled pin not seen after five cycles");

  bus_ok_a: assert property ($past(nrst) |->
    hreadyout && (hresp == SDP_HRESP_OKAY))
    else $error("slave stalled or answered an error");

  // a read captures data once; between reads the bus word stands
  rd_hold_a: assert property (!ap_rd |=> $stable(hrdata))
    else $error("read data moved without a read");

  // a refused size must leave every line setting as it was
  size_drop_a: assert property (odd_size_s |=> ##1
    $stable(io_out) && $stable(io_oe) && $stable(pull_up_en))
    else $error("non-word transfer changed a line setting");

  // output lines read back as the value they drive
  out_rd_a: assert property (in0_rd_s |=>
    ((hrdata ^ $past(io_out[31:0])) & $past(io_oe[31:0])) == 32'h0000_0000)
    else $error("input read hides a driven output value");

  // line build: a pull word sets up on ones and down on zeros
  pull_write_a: assert property (LINE_GRAN ##0 pull0_wr_s |=>
    (pull_up_en[31:0] == $past(hwdata)) &&
    (pull_dn_en[31:0] == ~$past(hwdata)))
    else $error("pull word 0 not applied");

  // port build: one port bit drives all eight direction bits
  port_wr_a: assert property (!LINE_GRAN ##0 pdir_wr_s |=>
    (io_oe[7:0] == {8{$past(hwdata[0])}}) &&
    (io_oe[95:88] == {8{$past(hwdata[11])}}))
    else $error("port direction word not spread to its lines");

  // line build ignores the port word, port build the line words
  pdir_skip_a: assert property (LINE_GRAN ##0 pdir_wr_s |=>
    $stable(io_oe))
    else $error("line build took a port direction write");

  dir_skip_a: assert property (!LINE_GRAN && dp_wr_q &&
    (dp_addr_q[31:4] == SDP_DIR_BASE[31:4]) |=> $stable(io_oe))
    else $error("port build took a line direction write");

  // the port word reads back port directions, or zero in the line build
  pdir_read_a: assert property (!LINE_GRAN ##0 pdir_rd_s |=>
    (hrdata[0] == $past(io_oe[0])) && (hrdata[11] == $past(io_oe[88])) &&
    (hrdata[31:12] == 20'h0_0000))
    else $error("port direction read does not match the lines");

  pdir_zero_a: assert property (LINE_GRAN ##0 pdir_rd_s |=>
    hrdata == 32'h0000_0000)
    else $error("line build shows a port direction word");

  // line build: the direction word reads back the line directions
  dir_read_a: assert property (LINE_GRAN ##0 dir0_rd_s |=>
    hrdata == $past(io_oe[31:0]))
    else $error("direction word 0 reads back wrong");
endmodule // sdp_top

//--- sim/sdp_world.sv
`timescale 1ns/1ns
// far side: switches or ttl sources, else the pull resistors
module sdp_world (
  // device side
  input wire logic [95:0] io_out,
  input wire logic [95:0] io_oe,
  input wire logic [95:0] pull_up_en,
  input wire logic [95:0] pull_dn_en,
  // external sources
  input wire logic [95:0] drv_en,
  input wire logic [95:0] drv_val,
  output logic [95:0] pin
);
  // a driven output wins, a source beats a pull, a bare line reads the inverse of drv_val
  assign pin = (io_oe & io_out) | (~io_oe & drv_en & drv_val)
    | (~io_oe & ~drv_en & pull_up_en)
    | (~io_oe & ~drv_en & ~pull_up_en & ~pull_dn_en & ~drv_val);
endmodule // sdp_world

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sdp_pkg::*;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, rd_dp = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, d, o, e, p;
  logic [95:0] drv_en = 0, drv_val = 0, x;
  logic hreadyout, hrdy_p;
  logic [1:0] hresp;
  logic [31:0] hrdata;
  logic [95:0] io_in, io_out, io_oe, pu, pd, oe_p;
  int mismatches = 0, num_checks = 0, cyc = 0;
  logic [31:0] expq[$];
  always #25 clk = ~clk;
  sdp_top #(.LINE_GRAN(1'b1)) sdp_top_i (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .pull_up_en(pu), .pull_dn_en(pd));
  // port build shares the bus; only its directions are watched
  sdp_top #(.LINE_GRAN(1'b0)) sdp_top_pb_i (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hrdy_p), .hreadyout(hrdy_p),
    .hresp(), .hrdata(), .io_in(io_in), .io_out(), .io_oe(oe_p),
    .pull_up_en(), .pull_dn_en());
  sdp_world sdp_world_i (.io_out(io_out), .io_oe(io_oe), .pull_up_en(pu),
    .pull_dn_en(pd), .drv_en(drv_en), .drv_val(drv_val), .pin(io_in));
  task automatic chk(input logic [191:0] seen, input logic [191:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // one word transfer; a read notes its expected data for the monitor
  task automatic xfer(input logic w, input logic [31:0] a, dat, ex);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (!w) expq.push_back(ex);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  // read data stands in the data phase, taken at its closing edge
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1) chk(hrdata, expq.pop_front());
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, generous against the roughly 80 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h0d1b6db7));
    repeat (6) @(posedge clk);
    nrst <= 1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    chk(io_oe, '0);
    chk({pu, pd}, {96'h0, {96{1'b1}}});
    xfer(0, SDP_OUT_BASE, 0, 32'h0);
    // every word driven out with random data, read back through IN
    for (int w = 0; w < 3; w++) begin
      o = $urandom;
      x[w*32 +: 32] = o;
      xfer(1, SDP_OUT_BASE + 4*w, o, 0);
      xfer(1, SDP_DIR_BASE + 4*w, 32'hFFFF_FFFF, 0);
      xfer(0, SDP_IN_BASE + 4*w, 0, o);
    end
    chk({io_out, io_oe}, {x, {96{1'b1}}});
    // mixed directions in one port, sources on the inputs
    d = 32'h0000_00A5;
    o = x[31:0];
    drv_val <= {$urandom, $urandom, $urandom};
    drv_en <= '1;
    xfer(1, SDP_DIR_BASE, d, 0);
    xfer(1, SDP_DIR_BASE + 4, 0, 0);
    repeat (6) @(posedge clk);
    chk(io_oe[31:0], d);
    xfer(0, SDP_DIR_BASE, 0, d);
    xfer(0, SDP_IN_BASE, 0, (o & d) | (drv_val[31:0] & ~d));
    xfer(0, SDP_IN_BASE + 4, 0, drv_val[63:32]);
    // pins change with no access: held read data must not move
    e = hrdata;
    drv_val <= ~drv_val;
    repeat (8) @(posedge clk);
    chk(hrdata, e);
    // sources released, pulls decide the inputs only
    p = $urandom;
    drv_en <= '0;
    xfer(1, SDP_PULL_BASE, p, 0);
    repeat (6) @(posedge clk);
    chk({pu[31:0], pd[31:0]}, {p, ~p});
    xfer(0, SDP_IN_BASE, 0, (o & d) | (p & ~d));
    // whole-port direction, ignored by the line build
    xfer(1, SDP_PDIR_OFS, 32'h0000_0805, 0);
    xfer(0, SDP_PDIR_OFS, 0, 32'h0);
    xfer(1, SDP_IN_BASE, 32'hFFFF_FFFF, 0);
    xfer(0, 32'h0000_0044, 0, 32'h0);
    xfer(0, SDP_IN_BASE, 0, (o & d) | (p & ~d));
    // a byte-size write is refused and leaves the output word alone
    hsize <= 3'h0;
    xfer(1, SDP_OUT_BASE, ~o, 0);
    hsize <= SDP_HSIZE_WORD;
    xfer(0, SDP_OUT_BASE, 0, o);
    @(posedge clk);
    chk(oe_p, {8'hFF, {8{8'h00}}, 8'hFF, 8'h00, 8'hFF});
    chk(io_oe[31:0], d);
    chk(hresp, SDP_HRESP_OKAY);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule // tb_top
